// *** hw/rpph_defs.svh ***
/*
  constants for the payload serial port block: clock, rates, selects,
  command codes and reset values. assumes nothing; included by bare name.
*/
`ifndef RPPH_DEFS_SVH
`define RPPH_DEFS_SVH

`define RPPH_CLK_PERIOD_NS 100
`define RPPH_NS_PER_SEC 1000000000
`define RPPH_CLK_HZ (`RPPH_NS_PER_SEC / `RPPH_CLK_PERIOD_NS)

`define RPPH_RATE_300 300
`define RPPH_RATE_1200 1200
`define RPPH_RATE_2400 2400
`define RPPH_RATE_4800 4800
`define RPPH_RATE_9600 9600
`define RPPH_RATE_19200 19200
`define RPPH_RATE_38400 38400
`define RPPH_RATE_57600 57600
`define RPPH_RATE_115200 115200

`define RPPH_BSEL_300 4'h0
`define RPPH_BSEL_1200 4'h1
`define RPPH_BSEL_2400 4'h2
`define RPPH_BSEL_4800 4'h3
`define RPPH_BSEL_9600 4'h4
`define RPPH_BSEL_19200 4'h5
`define RPPH_BSEL_38400 4'h6
`define RPPH_BSEL_57600 4'h7
`define RPPH_BSEL_115200 4'h8
`define RPPH_BSEL_RST `RPPH_BSEL_9600

`define RPPH_CMD_BAUD 3'h0
`define RPPH_CMD_CTS 3'h1
`define RPPH_CMD_DEVICE 3'h2
`define RPPH_CMD_ALARM 3'h3
`define RPPH_CMD_KEY 3'h4
`define RPPH_CMD_DKEY 3'h5
`define RPPH_CMD_ALMLVL 3'h6

`define RPPH_CTS_DLY_RST 8'h00
// pin sync reset {txd, sleep_n, rts}: idle levels, so reset fakes no request
`define RPPH_PIN_RST 3'h6
`define RPPH_MODE_DCE 1'b0
`define RPPH_MODE_CTSKEY 1'b1
`define RPPH_ALM_ACT_RST 1'b0
`define RPPH_DATA_BITS 4'h8
`define RPPH_FRAME_BITS 4'h9

`endif

// *** hw/rpph_pkg.sv ***
/*
  types shared by the payload serial port modules.
  assumes rpph_defs.svh is compiled alongside.
*/
package rpph_pkg;
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_CLEAR} rpph_cts_e;
  typedef enum logic [1:0] {US_IDLE, US_START, US_DATA, US_STOP} rpph_ust_e;
  typedef logic [7:0] rpph_byte_t;
endpackage

// *** hw/rpph_uart_if.sv ***
/*
  carrier between the port control and its serialiser.
  assumes one clock domain; ser_in already synchronised by the core.
*/
`timescale 1ns/1ps
`default_nettype none
interface rpph_uart_if #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] div;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_ready;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_ferr;
  logic ser_out;
  logic ser_in;
  modport core (output div, output tx_valid, output tx_data, input tx_ready,
    input rx_valid, input rx_data, input rx_ferr, input ser_out, output ser_in);
  modport uart (input div, input tx_valid, input tx_data, output tx_ready,
    output rx_valid, output rx_data, output rx_ferr, output ser_out, input ser_in);
endinterface
`default_nettype wire

// *** hw/rpph_uart.sv ***
/*
  8n1 asynchronous serialiser and deserialiser, bit time set by div cycles.
  assumes ser_in is already synchronised and tx_valid only while tx_ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rpph_defs.svh"
module rpph_uart
  import rpph_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  rpph_uart_if.uart u
);
  rpph_ust_e tst_ff, nxt_tst, rst_ff, nxt_rst;
  logic [DIV_W-1:0] tcnt_ff, nxt_tcnt, rcnt_ff, nxt_rcnt;
  logic [3:0] tbit_ff, nxt_tbit, rbit_ff, nxt_rbit;
  logic [7:0] tsh_ff, nxt_tsh, rsh_ff, nxt_rsh;
  logic out_ff, nxt_out, rv_ff, nxt_rv, fe_ff, nxt_fe;

  assign u.tx_ready = (tst_ff == US_IDLE);
  assign u.ser_out = out_ff;
  assign u.rx_valid = rv_ff;
  assign u.rx_data = rsh_ff;
  assign u.rx_ferr = fe_ff;

  // transmit: start bit, eight data lsb first, stop; line idles at mark
  always_comb begin
    nxt_tst = tst_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tbit = tbit_ff;
    nxt_tsh = tsh_ff;
    nxt_out = out_ff;
    unique case (tst_ff)
      US_IDLE: begin
        nxt_out = 1'b1;
        if (u.tx_valid) begin
          nxt_tsh = u.tx_data;
          nxt_out = 1'b0;
          nxt_tcnt = '0;
          nxt_tbit = '0;
          nxt_tst = US_DATA;
        end
      end
      US_DATA, US_STOP, US_START: begin
        nxt_tcnt = tcnt_ff + 1'b1;
        if (tcnt_ff >= u.div - 1'b1) begin
          nxt_tcnt = '0;
          nxt_tbit = tbit_ff + 4'h1;
          if (tbit_ff == `RPPH_DATA_BITS) begin
            nxt_out = 1'b1;
            nxt_tst = US_STOP;
          end else begin
            nxt_out = tsh_ff[0];
            nxt_tsh = {1'b1, tsh_ff[7:1]};
          end
          if (tst_ff == US_STOP) begin
            nxt_tst = US_IDLE;
          end
        end
      end
    endcase
  end

  // receive: centre-sample each bit; bad stop bit flags a rate mismatch
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rcnt = rcnt_ff + 1'b1;
    nxt_rbit = rbit_ff;
    nxt_rsh = rsh_ff;
    nxt_rv = 1'b0;
    nxt_fe = 1'b0;
    unique case (rst_ff)
      US_IDLE: begin
        nxt_rcnt = '0;
        if (!u.ser_in) begin
          nxt_rst = US_START;
        end
      end
      US_START: begin
        if (rcnt_ff >= (u.div >> 1)) begin
          nxt_rcnt = '0;
          nxt_rbit = '0;
          nxt_rst = u.ser_in ? US_IDLE : US_DATA;
        end
      end
      US_DATA: begin
        if (rcnt_ff >= u.div - 1'b1) begin
          nxt_rcnt = '0;
          nxt_rsh = {u.ser_in, rsh_ff[7:1]};
          nxt_rbit = rbit_ff + 4'h1;
          if (rbit_ff == `RPPH_DATA_BITS - 4'h1) begin
            nxt_rst = US_STOP;
          end
        end
      end
      US_STOP: begin
        if (rcnt_ff >= u.div - 1'b1) begin
          nxt_rv = u.ser_in;
          nxt_fe = !u.ser_in;
          nxt_rst = US_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      tst_ff <= US_IDLE;
      rst_ff <= US_IDLE;
      tcnt_ff <= '0;
      rcnt_ff <= '0;
      tbit_ff <= '0;
      rbit_ff <= '0;
      tsh_ff <= '0;
      rsh_ff <= '0;
      out_ff <= 1'b1;
      rv_ff <= 1'b0;
      fe_ff <= 1'b0;
    end else begin
      tst_ff <= nxt_tst;
      rst_ff <= nxt_rst;
      tcnt_ff <= nxt_tcnt;
      rcnt_ff <= nxt_rcnt;
      tbit_ff <= nxt_tbit;
      rbit_ff <= nxt_rbit;
      tsh_ff <= nxt_tsh;
      rsh_ff <= nxt_rsh;
      out_ff <= nxt_out;
      rv_ff <= nxt_rv;
      fe_ff <= nxt_fe;
    end
  end
endmodule
`default_nettype wire

// *** hw/rpph_top.sv ***
/*
  payload serial port of a telemetry radio, DCE side: data, carrier detect,
  alarm, request/clear-to-send keying, sleep and a small command port.
  assumes the radio modem and alarm sources run on CORE_CLK; pins are async.
*/
// Behaviour
// - nine selectable rates, 300 to 115200
// - asynchronous character framing only
// - port fixed in DCE role
// - carrier detect low while radio receives
// - radio data serialised onto receive-data output
// - grounded sleep input enters low power
// - alarm output space on alarm, configurable
// - request-to-send keys the transmitter
// - DCE: clear-to-send after programmed delay
// - CTS key: clear-to-send on radio data
// - alarm conditions recorded, readable by command
// - tolerance and rate mismatch are minor alarms
// - hardware failures are separate major alarms
// - command without argument queries or acts
// - command with argument sets the value
// - clear-to-send delay zero to 255 seconds
`timescale 1ns/1ps
`default_nettype none
`include "rpph_defs.svh"
module rpph_top
  import rpph_pkg::*;
#(
  parameter int TICKS_PER_SEC = `RPPH_CLK_HZ,
  parameter int DIV_W = 16
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic TXD,
  input wire logic RTS,
  input wire logic SLEEP_N,
  output logic RXD,
  output logic DCD_N,
  output logic CTS,
  output logic ALARM,
  input wire logic RADIO_CARRIER,
  input wire logic RADIO_RX_VALID,
  input wire logic [7:0] RADIO_RX_DATA,
  output logic RADIO_RX_READY,
  output logic TX_KEY,
  output logic TX_DATA_VALID,
  output logic [7:0] TX_DATA,
  output logic LOW_POWER,
  input wire logic [6:0] MINOR_COND,
  input wire logic [7:0] MAJOR_COND,
  output logic MINOR_ALARM,
  output logic MAJOR_ALARM,
  input wire logic MGMT_CMD_VALID,
  input wire logic [2:0] MGMT_CMD,
  input wire logic MGMT_HAS_ARG,
  input wire logic [15:0] MGMT_ARG,
  output logic MGMT_RSP_VALID,
  output logic MGMT_RSP_ERR,
  output logic [15:0] MGMT_RSP_DATA
);
  localparam int SUB_W = $clog2(TICKS_PER_SEC + 1);

  function automatic logic [DIV_W-1:0] rate_div(input logic [3:0] sel);
    int rate;
    rate = `RPPH_RATE_9600;
    unique case (sel)
      `RPPH_BSEL_300: rate = `RPPH_RATE_300;
      `RPPH_BSEL_1200: rate = `RPPH_RATE_1200;
      `RPPH_BSEL_2400: rate = `RPPH_RATE_2400;
      `RPPH_BSEL_4800: rate = `RPPH_RATE_4800;
      `RPPH_BSEL_9600: rate = `RPPH_RATE_9600;
      `RPPH_BSEL_19200: rate = `RPPH_RATE_19200;
      `RPPH_BSEL_38400: rate = `RPPH_RATE_38400;
      `RPPH_BSEL_57600: rate = `RPPH_RATE_57600;
      `RPPH_BSEL_115200: rate = `RPPH_RATE_115200;
      default: rate = `RPPH_RATE_9600;
    endcase
    return DIV_W'(`RPPH_CLK_HZ / rate);
  endfunction

  rpph_uart_if #(.DIV_W(DIV_W)) u ();

  rpph_uart #(.DIV_W(DIV_W)) u_ser (
    .CORE_CLK(CORE_CLK),
    .RESETN(RESETN),
    .u(u.uart)
  );

  // pin synchronisers; first stage read only by the second
  logic [2:0] pin_a_ff, pin_b_ff;
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pin_a_ff <= `RPPH_PIN_RST;
      pin_b_ff <= `RPPH_PIN_RST;
    end else begin
      pin_a_ff <= {TXD, SLEEP_N, RTS};
      pin_b_ff <= pin_a_ff;
    end
  end
  logic rts_s, sleep_s;
  assign rts_s = pin_b_ff[0];
  assign sleep_s = !pin_b_ff[1];
  assign u.ser_in = pin_b_ff[2];

  // settings held behind the command port
  logic [3:0] bsel_ff, nxt_bsel;
  logic [7:0] ctsdly_ff, nxt_ctsdly;
  logic mode_ff, nxt_mode;
  logic almact_ff, nxt_almact;
  logic tkey_ff, nxt_tkey;
  logic [15:0] evt_ff, nxt_evt;
  logic mism_ff, nxt_mism;
  logic rv_ff, nxt_rv, rerr_ff, nxt_rerr;
  logic [15:0] rdat_ff, nxt_rdat;
  logic [15:0] evt_now;

  assign u.div = rate_div(bsel_ff);
  assign evt_now = {MAJOR_COND, MINOR_COND, u.rx_ferr};

  always_comb begin
    nxt_bsel = bsel_ff;
    nxt_ctsdly = ctsdly_ff;
    nxt_mode = mode_ff;
    nxt_almact = almact_ff;
    nxt_tkey = tkey_ff;
    nxt_rv = MGMT_CMD_VALID;
    nxt_rerr = 1'b0;
    nxt_rdat = '0;
    nxt_evt = evt_ff;
    nxt_mism = mism_ff;
    if (MGMT_CMD_VALID) begin
      unique case (MGMT_CMD)
        `RPPH_CMD_BAUD: begin
          if (MGMT_HAS_ARG && MGMT_ARG[3:0] <= `RPPH_BSEL_115200 && MGMT_ARG[15:4] == '0) begin
            nxt_bsel = MGMT_ARG[3:0];
          end else if (MGMT_HAS_ARG) begin
            nxt_rerr = 1'b1;
          end
          nxt_rdat = {12'h000, nxt_bsel};
        end
        `RPPH_CMD_CTS: begin
          if (MGMT_HAS_ARG && MGMT_ARG[15:8] == '0) begin
            nxt_ctsdly = MGMT_ARG[7:0];
          end else if (MGMT_HAS_ARG) begin
            nxt_rerr = 1'b1;
          end
          nxt_rdat = {8'h00, nxt_ctsdly};
        end
        `RPPH_CMD_DEVICE: begin
          if (MGMT_HAS_ARG) begin
            nxt_mode = MGMT_ARG[0];
          end
          nxt_rdat = {15'h0000, nxt_mode};
        end
        `RPPH_CMD_ALARM: begin
          // read clears the record; a condition present now is kept
          nxt_rdat = evt_ff;
          nxt_evt = '0;
          nxt_mism = 1'b0;
          nxt_rerr = MGMT_HAS_ARG;
        end
        `RPPH_CMD_KEY: begin
          nxt_tkey = 1'b1;
          nxt_rerr = MGMT_HAS_ARG;
        end
        `RPPH_CMD_DKEY: begin
          nxt_tkey = 1'b0;
          nxt_rerr = MGMT_HAS_ARG;
        end
        `RPPH_CMD_ALMLVL: begin
          if (MGMT_HAS_ARG) begin
            nxt_almact = MGMT_ARG[0];
          end
          nxt_rdat = {15'h0000, nxt_almact};
        end
        default: begin
          nxt_rerr = 1'b1;
        end
      endcase
    end
    nxt_evt = nxt_evt | evt_now;
    nxt_mism = nxt_mism | u.rx_ferr;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      bsel_ff <= `RPPH_BSEL_RST;
      ctsdly_ff <= `RPPH_CTS_DLY_RST;
      mode_ff <= `RPPH_MODE_DCE;
      almact_ff <= `RPPH_ALM_ACT_RST;
      tkey_ff <= 1'b0;
      evt_ff <= '0;
      mism_ff <= 1'b0;
      rv_ff <= 1'b0;
      rerr_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      bsel_ff <= nxt_bsel;
      ctsdly_ff <= nxt_ctsdly;
      mode_ff <= nxt_mode;
      almact_ff <= nxt_almact;
      tkey_ff <= nxt_tkey;
      evt_ff <= nxt_evt;
      mism_ff <= nxt_mism;
      rv_ff <= nxt_rv;
      rerr_ff <= nxt_rerr;
      rdat_ff <= nxt_rdat;
    end
  end

  // radio to equipment: one-byte holding slot ahead of the serialiser
  logic pend_ff, nxt_pend, rdy_ff, nxt_rdy;
  logic [7:0] hold_ff, nxt_hold;
  logic push;
  assign push = pend_ff && u.tx_ready;
  assign u.tx_valid = push;
  assign u.tx_data = hold_ff;

  always_comb begin
    nxt_pend = pend_ff && !push;
    nxt_hold = hold_ff;
    if (RADIO_RX_VALID && rdy_ff) begin
      nxt_pend = 1'b1;
      nxt_hold = RADIO_RX_DATA;
    end
    // sleeping holds off new radio bytes
    nxt_rdy = !nxt_pend && !sleep_s;
  end

  // clear-to-send sequencing
  rpph_cts_e cst_ff, nxt_cst;
  logic [SUB_W-1:0] sub_ff, nxt_sub;
  logic [7:0] sec_ff, nxt_sec;
  logic cts_ff, nxt_cts, key_ff, nxt_key;

  always_comb begin
    nxt_cst = cst_ff;
    nxt_sub = '0;
    nxt_sec = sec_ff;
    unique case (cst_ff)
      CS_IDLE: begin
        nxt_sec = '0;
        if (rts_s && !sleep_s && mode_ff == `RPPH_MODE_DCE) begin
          nxt_cst = (ctsdly_ff == '0) ? CS_CLEAR : CS_WAIT;
        end
      end
      CS_WAIT: begin
        nxt_sub = sub_ff + 1'b1;
        if (sub_ff == SUB_W'(TICKS_PER_SEC - 1)) begin
          nxt_sub = '0;
          nxt_sec = sec_ff + 8'h01;
          if (sec_ff + 8'h01 == ctsdly_ff) begin
            nxt_cst = CS_CLEAR;
          end
        end
      end
      CS_CLEAR: begin
        nxt_cst = CS_CLEAR;
      end
    endcase
    if (!rts_s || sleep_s || mode_ff != `RPPH_MODE_DCE) begin
      nxt_cst = CS_IDLE;
    end
    if (mode_ff == `RPPH_MODE_CTSKEY) begin
      // keys the next radio for as long as radio data is in flight
      nxt_cts = RADIO_CARRIER || nxt_pend || pend_ff || !u.tx_ready;
    end else begin
      nxt_cts = (nxt_cst == CS_CLEAR);
    end
    nxt_key = (rts_s || tkey_ff) && !sleep_s;
  end

  logic dcd_ff, alm_ff, mina_ff, maja_ff, lp_ff, tv_ff;
  logic [7:0] td_ff;
  logic minor_any, major_any;
  assign minor_any = (|MINOR_COND) || mism_ff;
  assign major_any = |MAJOR_COND;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pend_ff <= 1'b0;
      hold_ff <= '0;
      rdy_ff <= 1'b0;
      cst_ff <= CS_IDLE;
      sub_ff <= '0;
      sec_ff <= '0;
      cts_ff <= 1'b0;
      key_ff <= 1'b0;
      dcd_ff <= 1'b1;
      alm_ff <= 1'b1;
      mina_ff <= 1'b0;
      maja_ff <= 1'b0;
      lp_ff <= 1'b0;
      tv_ff <= 1'b0;
      td_ff <= '0;
    end else begin
      pend_ff <= nxt_pend;
      hold_ff <= nxt_hold;
      rdy_ff <= nxt_rdy;
      cst_ff <= nxt_cst;
      sub_ff <= nxt_sub;
      sec_ff <= nxt_sec;
      cts_ff <= nxt_cts;
      key_ff <= nxt_key;
      dcd_ff <= !RADIO_CARRIER;
      alm_ff <= (minor_any || major_any) ? almact_ff : !almact_ff;
      mina_ff <= minor_any;
      maja_ff <= major_any;
      lp_ff <= sleep_s;
      tv_ff <= u.rx_valid;
      td_ff <= u.rx_valid ? u.rx_data : td_ff;
    end
  end

  // outputs are DCE-direction only; no terminal-role pinout exists
  assign RXD = u.ser_out;
  assign DCD_N = dcd_ff;
  assign CTS = cts_ff;
  assign ALARM = alm_ff;
  assign RADIO_RX_READY = rdy_ff;
  assign TX_KEY = key_ff;
  assign TX_DATA_VALID = tv_ff;
  assign TX_DATA = td_ff;
  assign LOW_POWER = lp_ff;
  assign MINOR_ALARM = mina_ff;
  assign MAJOR_ALARM = maja_ff;
  assign MGMT_RSP_VALID = rv_ff;
  assign MGMT_RSP_ERR = rerr_ff;
  assign MGMT_RSP_DATA = rdat_ff;
endmodule
`default_nettype wire

// *** tb/rpph_sva.sv ***
/*
  concurrent checks on the payload serial port top.
  assumes TICKS_PER_SEC small; sees only top ports, bound after the module.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rpph_defs.svh"
module rpph_sva (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic RTS,
  input wire logic SLEEP_N,
  input wire logic DCD_N,
  input wire logic CTS,
  input wire logic ALARM,
  input wire logic RADIO_CARRIER,
  input wire logic RADIO_RX_READY,
  input wire logic TX_KEY,
  input wire logic LOW_POWER,
  input wire logic [6:0] MINOR_COND,
  input wire logic [7:0] MAJOR_COND,
  input wire logic MINOR_ALARM,
  input wire logic MAJOR_ALARM,
  input wire logic MGMT_CMD_VALID,
  input wire logic [2:0] MGMT_CMD,
  input wire logic MGMT_HAS_ARG,
  input wire logic [15:0] MGMT_ARG,
  input wire logic MGMT_RSP_VALID,
  input wire logic MGMT_RSP_ERR,
  input wire logic [15:0] MGMT_RSP_DATA
);
  // shadow of mode and alarm level, so checks know which setting applies
  logic dce_ff, nxt_dce_ff, lvl_ff, nxt_lvl_ff;
  always_comb begin
    nxt_dce_ff = dce_ff;
    nxt_lvl_ff = lvl_ff;
    if (MGMT_CMD_VALID && MGMT_HAS_ARG) begin
      if (MGMT_CMD == `RPPH_CMD_DEVICE) nxt_dce_ff = ~MGMT_ARG[0];
      if (MGMT_CMD == `RPPH_CMD_ALMLVL) nxt_lvl_ff = MGMT_ARG[0];
    end
  end
  always_ff @(posedge CORE_CLK) begin
    dce_ff <= RESETN ? nxt_dce_ff : 1'b1;
    lvl_ff <= RESETN ? nxt_lvl_ff : 1'b0;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  AST_DCD_LOW: assert property (RADIO_CARRIER |=> !DCD_N)
    else $error("carrier detect not low");
  AST_SLEEP: assert property ((!SLEEP_N)[*4] |-> LOW_POWER && !TX_KEY && !RADIO_RX_READY)
    else $error("sleep not honoured");
  AST_RTS_KEY: assert property ((RTS && SLEEP_N)[*4] |-> TX_KEY)
    else $error("transmitter not keyed");
  AST_CTS_WAIT: assert property (dce_ff && $rose(CTS) |-> $past(RTS, 2))
    else $error("clear to send without request");
  AST_CTS_KEY: assert property (!dce_ff && RADIO_CARRIER |-> ##[1:2] CTS)
    else $error("clear to send not keyed");
  AST_RTS_DROP: assert property ((dce_ff && !RTS)[*5] |-> !CTS)
    else $error("clear to send held");
  AST_MINOR: assert property (|MINOR_COND |-> ##[1:2] MINOR_ALARM)
    else $error("minor alarm missing");
  AST_MAJOR_SEP: assert property ((MAJOR_COND == 8'h00)[*3] |-> !MAJOR_ALARM)
    else $error("major alarm without cause");
  AST_ALARM_LVL: assert property (MINOR_ALARM || MAJOR_ALARM |-> ##[0:2] ALARM == lvl_ff)
    else $error("alarm pin level wrong");
  AST_RSP: assert property (MGMT_CMD_VALID |=> MGMT_RSP_VALID)
    else $error("no command response");
  AST_SET_CTS: assert property (MGMT_CMD_VALID && MGMT_CMD == `RPPH_CMD_CTS && MGMT_HAS_ARG |=>
    MGMT_RSP_ERR == ($past(MGMT_ARG) > 16'h00ff) &&
    (MGMT_RSP_ERR || MGMT_RSP_DATA == $past(MGMT_ARG)))
    else $error("delay set response wrong");
endmodule
bind rpph_top rpph_sva rpph_sva_inst (.CORE_CLK, .RESETN, .RTS, .SLEEP_N, .DCD_N, .CTS, .ALARM,
  .RADIO_CARRIER, .RADIO_RX_READY, .TX_KEY, .LOW_POWER, .MINOR_COND, .MAJOR_COND,
  .MINOR_ALARM, .MAJOR_ALARM, .MGMT_CMD_VALID, .MGMT_CMD, .MGMT_HAS_ARG, .MGMT_ARG,
  .MGMT_RSP_VALID, .MGMT_RSP_ERR, .MGMT_RSP_DATA);
`default_nettype wire

// *** tb/rpph_dte.sv ***
/*
  attached equipment model: sends 8n1 frames on TXD, decodes RXD.
  assumes DIV is clock cycles per bit, set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module rpph_dte (
  input wire logic CORE_CLK,
  input wire logic RXD,
  input wire logic [15:0] DIV,
  output var logic TXD
);
  logic [7:0] rx_byte;
  logic rx_stop;
  int rx_cnt = 0;
  initial TXD = 1'b1;
  // a zero stop bit lets the bench break framing on purpose
  task automatic send(input logic [7:0] b, input logic stop_bit);
    logic [9:0] frame;
    frame = {stop_bit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge CORE_CLK);
      TXD <= frame[i];
      repeat (DIV - 1) @(posedge CORE_CLK);
    end
    @(posedge CORE_CLK);
    TXD <= 1'b1;
  endtask
  // sampled on the falling edge, away from the design's launch edge
  always begin
    @(negedge RXD);
    repeat (DIV / 2) @(negedge CORE_CLK);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(negedge CORE_CLK);
      rx_byte[i] = RXD;
    end
    repeat (DIV) @(negedge CORE_CLK);
    rx_stop = RXD;
    rx_cnt++;
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
  bench for the payload serial port top: command table and serial cases, then reset,
  keying, sleep and alarm cases. assumes TICKS_PER_SEC of 10.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rpph_defs.svh"
module tb;
  typedef struct {logic [2:0] c; logic h; logic [15:0] a; logic e; logic [15:0] d;} rpph_row_s;
  logic clk = 1'b0;
  logic resetn, txd, rts, sleep_n, carrier, rx_valid, cmd_valid, has_arg;
  logic rxd, dcd_n, cts, alarm, rx_ready, tx_key, txv, lowp, min_a, maj_a, rsp_v, rsp_e;
  logic [7:0] rx_data, major, tx_data;
  logic [6:0] minor;
  logic [2:0] cmd;
  logic [15:0] arg, div, rsp_d;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  rpph_row_s rows [11] = '{'{`RPPH_CMD_DEVICE, 0, 0, 0, 0}, '{`RPPH_CMD_ALMLVL, 0, 0, 0, 0},
    '{`RPPH_CMD_CTS, 0, 0, 0, 0}, '{`RPPH_CMD_BAUD, 0, 0, 0, `RPPH_BSEL_9600},
    '{`RPPH_CMD_CTS, 1, 16'h00ff, 0, 16'h00ff}, '{`RPPH_CMD_CTS, 1, 16'h0100, 1, 0},
    '{`RPPH_CMD_CTS, 0, 0, 0, 16'h00ff}, '{`RPPH_CMD_BAUD, 1, 16'h0009, 1, 0},
    '{3'h7, 0, 0, 1, 0}, '{`RPPH_CMD_ALARM, 1, 16'h0001, 1, 0}, '{`RPPH_CMD_ALARM, 0, 0, 0, 0}};
  always #50 clk = ~clk;
  rpph_top #(.TICKS_PER_SEC(10)) rpph_top_inst (.CORE_CLK(clk), .RESETN(resetn), .TXD(txd),
    .RTS(rts), .SLEEP_N(sleep_n), .RXD(rxd), .DCD_N(dcd_n), .CTS(cts), .ALARM(alarm),
    .RADIO_CARRIER(carrier), .RADIO_RX_VALID(rx_valid), .RADIO_RX_DATA(rx_data),
    .RADIO_RX_READY(rx_ready), .TX_KEY(tx_key), .TX_DATA_VALID(txv), .TX_DATA(tx_data),
    .LOW_POWER(lowp), .MINOR_COND(minor), .MAJOR_COND(major), .MINOR_ALARM(min_a),
    .MAJOR_ALARM(maj_a), .MGMT_CMD_VALID(cmd_valid), .MGMT_CMD(cmd), .MGMT_HAS_ARG(has_arg),
    .MGMT_ARG(arg), .MGMT_RSP_VALID(rsp_v), .MGMT_RSP_ERR(rsp_e), .MGMT_RSP_DATA(rsp_d));
  rpph_dte rpph_dte_inst (.CORE_CLK(clk), .RXD(rxd), .DIV(div), .TXD(txd));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic send_cmd(input rpph_row_s r, input logic cd);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= r.c;
    has_arg <= r.h;
    arg <= r.a;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk("rsp valid", 16'h0001, {15'h0000, rsp_v});
    chk("rsp err", {15'h0000, r.e}, {15'h0000, rsp_e});
    if (cd) chk("rsp data", r.d, rsp_d);
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic radio_byte(input logic [7:0] b);
    int k;
    k = rpph_dte_inst.rx_cnt;
    for (n = 0; n < 50 && rx_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    for (n = 0; n < 12 * div && rpph_dte_inst.rx_cnt == k; n++) @(negedge clk);
    chk("rxd byte", {8'h00, b}, {8'h00, rpph_dte_inst.rx_byte});
    chk("rxd stop", 16'h0001, {15'h0000, rpph_dte_inst.rx_stop});
  endtask
  task automatic dte_byte(input logic [7:0] b, input logic stop, input logic expv);
    logic seen;
    seen = 1'b0;
    fork
      rpph_dte_inst.send(b, stop);
      repeat (12 * div) begin
        @(negedge clk);
        if (txv === 1'b1) seen = 1'b1;
      end
    join
    chk("tx valid", {15'h0000, expv}, {15'h0000, seen});
    if (expv) chk("tx data", {8'h00, b}, {8'h00, tx_data});
  endtask
  // ceiling well above the roughly 13000 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    {resetn, rts, carrier, rx_valid, cmd_valid, has_arg} = 6'h00;
    sleep_n = 1'b1;
    {rx_data, major, minor, cmd, arg} = 42'h000;
    div = 16'h0411;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 11; i++) send_cmd(rows[i], !rows[i].e);
    radio_byte(8'hc3);
    for (int s = 0; s < 9; s++) send_cmd('{`RPPH_CMD_BAUD, 1, s, 0, s}, 1);
    div = 16'h0056;
    radio_byte(8'h5a);
    dte_byte(8'ha5, 1'b1, 1'b1);
    dte_byte(8'h3c, 1'b0, 1'b0);
    chk("minor on mismatch", 16'h0002, {14'h0000, min_a, alarm});
    send_cmd('{`RPPH_CMD_ALARM, 0, 0, 0, 16'h0001}, 1);
    @(posedge clk);
    resetn <= 1'b0;
    settle(10);
    chk("reset outputs", 16'h0d00, {4'h0, rxd, dcd_n, cts, alarm, rx_ready, tx_key, txv, lowp,
      min_a, maj_a, rsp_v, rsp_e});
    @(posedge clk);
    resetn <= 1'b1;
    send_cmd('{`RPPH_CMD_BAUD, 0, 0, 0, `RPPH_BSEL_9600}, 1);
    send_cmd('{`RPPH_CMD_CTS, 1, 16'h0003, 0, 16'h0003}, 1);
    @(posedge clk);
    rts <= 1'b1;
    settle(4);
    chk("key on request", 16'h0002, {14'h0000, tx_key, cts});
    settle(20);
    chk("cts early", 16'h0000, {15'h0000, cts});
    settle(15);
    chk("cts late", 16'h0001, {15'h0000, cts});
    @(posedge clk);
    rts <= 1'b0;
    settle(6);
    chk("request dropped", 16'h0000, {14'h0000, tx_key, cts});
    @(posedge clk);
    rts <= 1'b1;
    sleep_n <= 1'b0;
    settle(6);
    chk("asleep", 16'h0008, {12'h000, lowp, tx_key, cts, rx_ready});
    @(posedge clk);
    sleep_n <= 1'b1;
    settle(6);
    chk("awake", 16'h0001, {14'h0000, lowp, tx_key});
    @(posedge clk);
    rts <= 1'b0;
    send_cmd('{`RPPH_CMD_KEY, 0, 0, 0, 0}, 0);
    settle(2);
    chk("test key", 16'h0001, {15'h0000, tx_key});
    send_cmd('{`RPPH_CMD_DKEY, 0, 0, 0, 0}, 0);
    settle(2);
    chk("test dekey", 16'h0000, {15'h0000, tx_key});
    send_cmd('{`RPPH_CMD_DEVICE, 1, 16'h0001, 0, 16'h0001}, 1);
    @(posedge clk);
    carrier <= 1'b1;
    settle(3);
    chk("carrier on", 16'h0001, {14'h0000, dcd_n, cts});
    @(posedge clk);
    carrier <= 1'b0;
    settle(3);
    chk("carrier off", 16'h0002, {14'h0000, dcd_n, cts});
    send_cmd('{`RPPH_CMD_DEVICE, 1, 16'h0000, 0, 16'h0000}, 1);
    @(posedge clk);
    minor <= 7'h04;
    settle(3);
    chk("minor alarm", 16'h0004, {13'h0000, min_a, maj_a, alarm});
    @(posedge clk);
    minor <= 7'h00;
    settle(4);
    send_cmd('{`RPPH_CMD_ALMLVL, 1, 16'h0001, 0, 16'h0001}, 1);
    @(posedge clk);
    major <= 8'h80;
    settle(3);
    chk("major alarm", 16'h0003, {14'h0000, maj_a, alarm});
    @(posedge clk);
    major <= 8'h00;
    settle(4);
    send_cmd('{`RPPH_CMD_ALARM, 0, 0, 0, 16'h8008}, 1);
    settle(3);
    chk("alarm normal", 16'h0000, {15'h0000, alarm});
    conclude();
  end
endmodule
`default_nettype wire
